// ===== logic/adcseq_pkg.sv
// Purpose: Shared constants and types of the converter sequencer.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes:   Control and configuration field layouts are carried by the packed structs below.
`default_nettype none
package adcseq_pkg;
    localparam int ADDR_W = 5;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_CFG     = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_COMMAND = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_INTCTRL = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_FLAGS   = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_RESULT  = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 5'h18;

    // Control register, low bits of OFF_CTRL.
    typedef struct packed {
        logic event_start_en;
        logic run_while_halted;
        logic res8;
        logic free_run;
        logic enable;
    } adcseq_ctrl_t;

    // Configuration register, low bits of OFF_CFG.
    typedef struct packed {
        logic [3:0] input_channel_select;
        logic [1:0] reference_select;
        logic [2:0] accumulation_count_select;
        logic [2:0] prescaler_select;
    } adcseq_cfg_t;

    localparam int CTRL_W = $bits(adcseq_ctrl_t);
    localparam int CFG_W  = $bits(adcseq_cfg_t);

    localparam adcseq_ctrl_t CTRL_RST = 5'h00;
    localparam adcseq_cfg_t  CFG_RST  = 12'h000;
    localparam logic [1:0]   REF_INTERNAL = 2'h0;

    // Converter clock cycles in one normal conversion.
    localparam logic [3:0] CONV_CYCLES = 4'hd;
    // Largest accumulation exponent (64 samples).
    localparam logic [2:0] ACC_LOG_MAX = 3'h6;
    // Bits dropped from a sample at the reduced resolution.
    localparam int         RES8_SHIFT  = 2;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : adcseq_pkg
`default_nettype wire

// ===== logic/adcseq_top.sv
// Purpose: Conversion sequencer for a successive-approximation converter.
// Assumes: Event input, debug halt and converter data share aclk.
// Notes:   Registers are reached over AXI4-Lite; one write, one read.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RQ1 - Converter clock comes from prescaled peripheral clock.
// RQ2 - Debug halt freezes converter unless run-while-halted.
// RQ3 - Software sets enable last when initialising.
// RQ4 - Reference defaults to internal reference after reset.
// RQ5 - Start bit reads one while converting.
// RQ6 - Single mode clears start bit at completion.
// RQ7 - Channel change waits for conversion end.
// RQ8 - Result is one sample or accumulated sum.
// RQ9 - Flag set on finish; interrupt needs both enables.
// RQ10 - Flag sets even with interrupt disabled.
// RQ11 - Enabled event input triggers a conversion.
// RQ12 - Event edge sets start bit until completion.
// RQ13 - Free run restarts immediately, flagging each result.
// RQ14 - Result codes span zero to full scale.
// RQ15 - Writing zero to start bit does nothing.
// RQ16 - Result is right adjusted.
// RQ17 - Conversion lasts thirteen converter clock cycles.
// RQ18 - Reading result or writing one clears flag.
// RQ19 - Prescaler held zero while converter disabled.
module adcseq_top #(
    parameter int RES_W = 10
) (
    // Clock, reset and freeze.
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       ce,
    // AXI4-Lite slave.
    input  wire logic [adcseq_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [adcseq_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // System side.
    input  wire logic                       event_in,
    input  wire logic                       debug_halt,
    input  wire logic                       global_int_enable,
    output logic                            irq,
    // Analog converter core.
    input  wire logic [RES_W-1:0]           sar_result,
    output logic                            sar_clk_tick,
    output logic                            sar_sample,
    output logic [3:0]                      sar_channel,
    output logic [1:0]                      sar_reference,
    output logic                            sar_enable
);
    import adcseq_pkg::*;

    localparam int ACC_W = RES_W + 6;

    if (RES_W <= RES8_SHIFT || ACC_W > 32) begin : g_bad_res
        $error("RES_W out of range");
    end

    // Last prescaler count: divide by two to the power of (select + 1).
    function automatic logic [7:0] prescaler_select_last(input logic [2:0] sel);
        prescaler_select_last = 8'((9'h002 << sel) - 9'h001);
    endfunction : prescaler_select_last

    // Byte-lane merge of a write into a stored value.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction : merge

    adcseq_ctrl_t      ctrl, next_ctrl;
    adcseq_cfg_t       cfg, next_cfg;
    logic              start_bit, next_start_bit;
    logic              int_en, next_int_en;
    logic              flag, next_flag;
    logic [ACC_W-1:0]  result, next_result;
    logic [ACC_W-1:0]  acc, next_acc;
    logic              busy, next_busy;
    logic [7:0]        prescaler_select_cnt, next_prescaler_select_cnt;
    logic [3:0]        cyc, next_cyc;
    logic [5:0]        nsamp, next_nsamp;
    logic              ev_prev, next_ev_prev;
    logic              sample_q, next_sample_q;
    logic [3:0]        chan_act, next_chan_act;
    logic [1:0]        ref_act, next_ref_act;
    logic              aw_held, next_aw_held;
    logic              w_held, next_w_held;
    logic [ADDR_W-1:0] awaddr_q, next_awaddr_q;
    logic [31:0]       wdata_q, next_wdata_q;
    logic [3:0]        wstrb_q, next_wstrb_q;
    logic              bvalid_q, next_bvalid_q;
    logic [1:0]        bresp_q, next_bresp_q;
    logic              rvalid_q, next_rvalid_q;
    logic [1:0]        rresp_q, next_rresp_q;
    logic [31:0]       rdata_q, next_rdata_q;

    logic              run, tick, ev_edge, start_set, sample_done, done;
    logic              do_wr, rd_hs, aw_have, w_have;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data, rd_word;
    logic [3:0]        wr_strb;
    logic [RES_W-1:0]  sample;
    logic [2:0]        acc_log;

    assign awready = ce && !aw_held && !bvalid_q;
    assign wready  = ce && !w_held && !bvalid_q;
    assign arready = ce && !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
    assign irq     = flag && int_en && global_int_enable; // RQ9
    assign sar_clk_tick  = tick;
    assign sar_sample    = sample_q;
    assign sar_channel   = chan_act;
    assign sar_reference = ref_act;
    assign sar_enable    = ctrl.enable;

    always_comb begin
        aw_have = aw_held || (awvalid && awready);
        w_have  = w_held || (wvalid && wready);
        wr_addr = aw_held ? awaddr_q : awaddr;
        wr_data = w_held ? wdata_q : wdata;
        wr_strb = w_held ? wstrb_q : wstrb;
        do_wr   = ce && aw_have && w_have && !bvalid_q;
        rd_hs   = arvalid && arready;
        case (araddr)
            OFF_CTRL:    rd_word = 32'(ctrl);
            OFF_CFG:     rd_word = 32'(cfg);
            OFF_COMMAND: rd_word = 32'(start_bit); // RQ5
            OFF_INTCTRL: rd_word = 32'(int_en);
            OFF_FLAGS:   rd_word = 32'(flag);
            OFF_RESULT:  rd_word = 32'(result); // RQ16
            OFF_STATUS:  rd_word = 32'({ref_act, chan_act, busy});
            default:     rd_word = 32'h0000_0000;
        endcase
        // Halt only the conversion logic; the bus stays usable for debug.
        run     = ce && (!debug_halt || ctrl.run_while_halted); // RQ2
        tick    = run && busy && ctrl.enable
                  && prescaler_select_cnt == prescaler_select_last(cfg.prescaler_select); // RQ1
        ev_edge = event_in && !ev_prev; // RQ12
        start_set = (do_wr && wr_addr == OFF_COMMAND && wr_strb[0]
                     && wr_data[0]) // RQ15
                    || (run && ctrl.event_start_en && ev_edge); // RQ11
        acc_log = (cfg.accumulation_count_select > ACC_LOG_MAX)
                  ? ACC_LOG_MAX : cfg.accumulation_count_select;
        sample  = ctrl.res8 ? (sar_result >> RES8_SHIFT) : sar_result; // RQ14
        sample_done = tick && cyc == CONV_CYCLES - 4'h1; // RQ17
        done    = sample_done && nsamp == 6'((7'h01 << acc_log) - 7'h01);

        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_awaddr_q = awaddr_q;
        next_wdata_q  = wdata_q;
        next_wstrb_q  = wstrb_q;
        next_bvalid_q = bvalid_q;
        next_bresp_q  = bresp_q;
        next_rvalid_q = rvalid_q;
        next_rresp_q  = rresp_q;
        next_rdata_q  = rdata_q;
        next_ctrl     = ctrl;
        next_cfg      = cfg;
        next_int_en   = int_en;
        next_start_bit = start_bit;
        next_flag     = flag;
        next_result   = result;
        next_acc      = acc;
        next_busy     = busy;
        next_prescaler_select_cnt = prescaler_select_cnt;
        next_cyc      = cyc;
        next_nsamp    = nsamp;
        next_ev_prev  = run ? event_in : ev_prev;
        next_sample_q = 1'b0;
        next_chan_act = chan_act;
        next_ref_act  = ref_act;

        if (awvalid && awready && !do_wr) begin
            next_aw_held  = 1'b1;
            next_awaddr_q = awaddr;
        end
        if (wvalid && wready && !do_wr) begin
            next_w_held  = 1'b1;
            next_wdata_q = wdata;
            next_wstrb_q = wstrb;
        end
        if (bvalid_q && bready && ce) begin
            next_bvalid_q = 1'b0;
        end
        if (rvalid_q && rready && ce) begin
            next_rvalid_q = 1'b0;
        end

        // Clears come first so that hardware events below win over them.
        if (do_wr) begin
            next_aw_held  = 1'b0;
            next_w_held   = 1'b0;
            next_bvalid_q = 1'b1;
            next_bresp_q  = RESP_OKAY;
            case (wr_addr)
                OFF_CTRL: next_ctrl = adcseq_ctrl_t'(
                    merge(32'(ctrl), wr_data, wr_strb));
                OFF_CFG: next_cfg = adcseq_cfg_t'(
                    merge(32'(cfg), wr_data, wr_strb));
                OFF_INTCTRL: next_int_en =
                    wr_strb[0] ? wr_data[0] : int_en;
                OFF_FLAGS: if (wr_strb[0] && wr_data[0]) begin
                    next_flag = 1'b0; // RQ18
                end
                OFF_COMMAND, OFF_RESULT, OFF_STATUS: ;
                default: next_bresp_q = RESP_SLVERR;
            endcase
        end
        if (rd_hs) begin
            next_rvalid_q = 1'b1;
            next_rdata_q  = rd_word;
            next_rresp_q  = (araddr > OFF_STATUS || araddr[1:0] != 2'b00)
                            ? RESP_SLVERR : RESP_OKAY;
            if (araddr == OFF_RESULT) begin
                next_flag = 1'b0; // RQ18
            end
        end

        if (start_set) begin
            next_start_bit = 1'b1; // RQ5
        end

        // Selections track software only between conversions.
        if (!busy) begin
            next_chan_act = cfg.input_channel_select; // RQ7
            next_ref_act  = cfg.reference_select;
        end

        if (!ctrl.enable) begin
            next_busy      = 1'b0;
            next_prescaler_select_cnt = 8'h00; // RQ19
        end else if (run) begin
            if (!busy) begin
                next_prescaler_select_cnt = 8'h00;
                if (start_bit) begin
                    next_busy     = 1'b1;
                    next_cyc      = 4'h0;
                    next_nsamp    = 6'h00;
                    next_acc      = '0;
                    next_sample_q = 1'b1;
                end
            end else begin
                next_prescaler_select_cnt = tick ? 8'h00 : prescaler_select_cnt + 8'h01; // RQ1
                if (tick) begin
                    next_cyc = cyc + 4'h1;
                end
                if (sample_done) begin
                    next_cyc   = 4'h0;
                    next_acc   = acc + ACC_W'(sample); // RQ8
                    next_nsamp = nsamp + 6'h01;
                    next_sample_q = 1'b1;
                end
                if (done) begin
                    next_result = acc + ACC_W'(sample); // RQ8
                    next_flag   = 1'b1; // RQ10
                    next_nsamp  = 6'h00;
                    next_acc    = '0;
                    next_chan_act = cfg.input_channel_select; // RQ7
                    next_ref_act  = cfg.reference_select;
                    if (!ctrl.free_run) begin
                        next_busy      = 1'b0;
                        next_sample_q  = 1'b0;
                        next_start_bit = start_set; // RQ6
                    end // RQ13
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RST;
            cfg  <= CFG_RST; // RQ4
            start_bit <= 1'b0;
            int_en    <= 1'b0;
            flag      <= 1'b0;
            result    <= '0;
            acc       <= '0;
            busy      <= 1'b0;
            prescaler_select_cnt <= 8'h00;
            cyc       <= 4'h0;
            nsamp     <= 6'h00;
            ev_prev   <= 1'b0;
            sample_q  <= 1'b0;
            chan_act  <= 4'h0;
            ref_act   <= REF_INTERNAL; // RQ4
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else if (ce) begin
            ctrl <= next_ctrl;
            cfg  <= next_cfg;
            start_bit <= next_start_bit;
            int_en    <= next_int_en;
            flag      <= next_flag;
            result    <= next_result;
            acc       <= next_acc;
            busy      <= next_busy;
            prescaler_select_cnt <= next_prescaler_select_cnt;
            cyc       <= next_cyc;
            nsamp     <= next_nsamp;
            ev_prev   <= next_ev_prev;
            sample_q  <= next_sample_q;
            chan_act  <= next_chan_act;
            ref_act   <= next_ref_act;
            aw_held   <= next_aw_held;
            w_held    <= next_w_held;
            awaddr_q  <= next_awaddr_q;
            wdata_q   <= next_wdata_q;
            wstrb_q   <= next_wstrb_q;
            bvalid_q  <= next_bvalid_q;
            bresp_q   <= next_bresp_q;
            rvalid_q  <= next_rvalid_q;
            rresp_q   <= next_rresp_q;
            rdata_q   <= next_rdata_q;
        end
    end

    property p_busy_start;
        @(posedge aclk) disable iff (!aresetn) busy |-> start_bit;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy without start"); // RQ5
    property p_single_clear;
        @(posedge aclk) disable iff (!aresetn)
        (ce && done && !ctrl.free_run && !start_set) |=> !start_bit && !busy;
    endproperty
    a_single_clear: assert property (p_single_clear) else $error("start kept"); // RQ6
    property p_flag_set;
        @(posedge aclk) disable iff (!aresetn) (ce && done) |=> flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RQ10
    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        (ce && done && int_en && global_int_enable) ##1 global_int_enable |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // RQ9
    property p_prescaler_select_off;
        @(posedge aclk) disable iff (!aresetn)
        (ce && !ctrl.enable) |=> prescaler_select_cnt == 8'h00 && !busy;
    endproperty
    a_prescaler_select_off: assert property (p_prescaler_select_off) else $error("prescaler ran"); // RQ19
    property p_chan_lock;
        @(posedge aclk) disable iff (!aresetn)
        (busy && $past(busy) && !$past(done)) |-> $stable(sar_channel);
    endproperty
    a_chan_lock: assert property (p_chan_lock) else $error("channel moved"); // RQ7
    property p_len;
        @(posedge aclk) disable iff (!aresetn)
        sample_done |-> cyc == 4'hc && $past(cyc) == 4'hc || $past(tick);
    endproperty
    a_len: assert property (p_len) else $error("bad conversion length"); // RQ17
    property p_event;
        @(posedge aclk) disable iff (!aresetn)
        (run && ctrl.event_start_en && event_in && !ev_prev) |=> start_bit;
    endproperty
    a_event: assert property (p_event) else $error("event lost"); // RQ11
    property p_halt;
        @(posedge aclk) disable iff (!aresetn)
        (debug_halt && !ctrl.run_while_halted && ctrl.enable)
        |=> $stable(prescaler_select_cnt) && $stable(cyc);
    endproperty
    a_halt: assert property (p_halt) else $error("ran while halted"); // RQ2
    property p_free;
        @(posedge aclk) disable iff (!aresetn)
        (ce && done && ctrl.free_run && ctrl.enable) |=> busy && sample_q;
    endproperty
    a_free: assert property (p_free) else $error("free run stopped"); // RQ13
    property p_rd_clear;
        @(posedge aclk) disable iff (!aresetn)
        (rd_hs && araddr == OFF_RESULT && !done) |=> !flag;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flag kept"); // RQ18
endmodule : adcseq_top
`default_nettype wire

// ===== testbench/adcseq_sar_model.sv
// Purpose: Behavioural analog converter core facing the sequencer.
// Assumes: The channel in use is settled one cycle after a sample pulse.
// Notes:   Channel zero reads as code zero and channel fifteen full scale.
`timescale 1ns/10ps
`default_nettype none
module adcseq_sar_model (
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Sequencer side.
    input  wire logic       sar_sample,
    input  wire logic       sar_enable,
    input  wire logic [3:0] sar_channel,
    output logic      [9:0] sar_result
);
    logic sample_d;
    // While disabled the code keeps toggling, so a stale value never passes.
    always_ff @(posedge aclk) begin
        sample_d <= sar_sample;
        if (!aresetn) begin
            sar_result <= 10'h000;
        end else if (sample_d) begin
            sar_result <= {sar_channel, sar_channel, sar_channel[3:2]};
        end else if (!sar_enable) begin
            sar_result <= ~sar_result;
        end
    end
endmodule : adcseq_sar_model
`default_nettype wire

// ===== testbench/adcseq_top_tb.sv
// Purpose: Self-checking bench of the conversion sequencer.
// Assumes: One AXI4-Lite write and one read in flight at most.
// Notes:   Ready and valid are judged at the falling edge, acted on after.
`timescale 1ns/10ps
`default_nettype none
module adcseq_top_tb;
    import adcseq_pkg::*;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_d;
    logic [3:0]  wstrb, sar_channel;
    logic [1:0]  bresp, rresp, sar_reference, resp;
    logic [9:0]  sar_result;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid;
    logic bready, arvalid, arready, rvalid, rready, event_in, debug_halt;
    logic global_int_enable, irq, sar_clk_tick, sar_sample, sar_enable, ok;
    int   miscompares, samples_checked;

    adcseq_top adcseq_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .event_in(event_in), .debug_halt(debug_halt),
        .global_int_enable(global_int_enable), .irq(irq),
        .sar_result(sar_result), .sar_clk_tick(sar_clk_tick),
        .sar_sample(sar_sample), .sar_channel(sar_channel),
        .sar_reference(sar_reference), .sar_enable(sar_enable));
    adcseq_sar_model adcseq_sar_model_i (.aclk(aclk), .aresetn(aresetn),
        .sar_sample(sar_sample), .sar_enable(sar_enable),
        .sar_channel(sar_channel), .sar_result(sar_result));

    always #5 aclk = ~aclk;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic aw_ok, w_ok, b_ok;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_ok = 1'b0;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a);
        logic a_ok, r_ok;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_ok = 1'b0;
        while (!r_ok) begin
            @(negedge aclk);
            a_ok = arvalid && arready;
            r_ok = rvalid;
            rd_d = rdata;
            resp = rresp;
            @(posedge aclk);
            if (a_ok) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : rd

    task automatic rdv(input logic [4:0] a, input logic [15:0] e);
        rd(a);
        chk(rd_d[15:0], e);
    endtask : rdv

    task automatic wait_flag();
        ok = 1'b0;
        for (int i = 0; i < 300 && !ok; i++) begin
            rd(OFF_FLAGS);
            ok = rd_d[0];
        end
        chk({15'h0000, ok}, 16'h0001);
    endtask : wait_flag

    task automatic test_reset();
        rdv(OFF_CTRL, 16'h0000);
        rdv(OFF_CFG, 16'h0000);
        rdv(OFF_STATUS, 16'h0000);
        rdv(5'h1c, 16'h0000);
        chk({14'h0000, resp}, {14'h0000, RESP_SLVERR});
        wr(5'h1c, 16'h0001);
        chk({14'h0000, resp}, {14'h0000, RESP_SLVERR});
        $display("reset test done");
    endtask : test_reset

    task automatic test_timing();
        int n;
        int lo;
        wr(OFF_INTCTRL, 16'h0001);
        global_int_enable <= 1'b1;
        wr(OFF_CFG, 16'h0200);
        wr(OFF_CTRL, 16'h0001);
        for (int p = 0; p < 3; p++) begin
            wr(OFF_CFG, 16'h0200 + 16'(p));
            wr(OFF_COMMAND, 16'h0001);
            n = 0;
            while (!irq && n < 1000) begin
                @(negedge aclk);
                n++;
            end
            lo = 13 << (p + 1);
            chk({15'h0000, n >= lo - 2 && n <= lo + 6}, 16'h0001);
            rdv(OFF_RESULT, 16'h0088);
            chk({15'h0000, irq}, 16'h0000);
        end
        $display("timing test done");
    endtask : test_timing

    task automatic test_poll();
        global_int_enable <= 1'b0;
        wr(OFF_CFG, 16'h0101);
        wr(OFF_COMMAND, 16'h0001);
        rdv(OFF_COMMAND, 16'h0001);
        wr(OFF_COMMAND, 16'h0000);
        wr(OFF_CFG, 16'h0fc1);
        rdv(OFF_STATUS, 16'h0003);
        rdv(OFF_COMMAND, 16'h0001);
        wait_flag();
        chk({14'h0000, sar_reference}, 16'h0003);
        chk({15'h0000, irq}, 16'h0000);
        rdv(OFF_COMMAND, 16'h0000);
        rdv(OFF_RESULT, 16'h0044);
        wr(OFF_COMMAND, 16'h0001);
        wait_flag();
        rdv(OFF_RESULT, 16'h03ff);
        wr(OFF_CTRL, 16'h0005);
        wr(OFF_COMMAND, 16'h0001);
        wait_flag();
        rdv(OFF_RESULT, 16'h00ff);
        wr(OFF_CFG, 16'h0000);
        wr(OFF_CTRL, 16'h0001);
        wr(OFF_COMMAND, 16'h0001);
        wait_flag();
        rdv(OFF_RESULT, 16'h0000);
        $display("poll test done");
    endtask : test_poll

    task automatic test_accum();
        global_int_enable <= 1'b1;
        wr(OFF_CFG, 16'h0410);
        wr(OFF_COMMAND, 16'h0001);
        wait_flag();
        chk({15'h0000, irq}, 16'h0001);
        rdv(OFF_RESULT, 16'h0444);
        wr(OFF_COMMAND, 16'h0001);
        wait_flag();
        wr(OFF_FLAGS, 16'h0001);
        rdv(OFF_FLAGS, 16'h0000);
        $display("accumulate test done");
    endtask : test_accum

    task automatic test_event();
        wr(OFF_CTRL, 16'h0011);
        wr(OFF_CFG, 16'h0300);
        event_in <= 1'b1;
        rdv(OFF_COMMAND, 16'h0001);
        wait_flag();
        rdv(OFF_RESULT, 16'h00cc);
        repeat (80) @(posedge aclk);
        rdv(OFF_FLAGS, 16'h0000);
        rdv(OFF_COMMAND, 16'h0000);
        event_in <= 1'b0;
        wr(OFF_CTRL, 16'h0001);
        event_in <= 1'b1;
        repeat (80) @(posedge aclk);
        rdv(OFF_FLAGS, 16'h0000);
        event_in <= 1'b0;
        $display("event test done");
    endtask : test_event

    task automatic test_debug();
        wr(OFF_COMMAND, 16'h0001);
        repeat (4) @(posedge aclk);
        // A low clock enable must freeze the conversion in flight.
        ce <= 1'b0;
        repeat (100) @(posedge aclk);
        ce <= 1'b1;
        rdv(OFF_FLAGS, 16'h0000);
        debug_halt <= 1'b1;
        repeat (100) @(posedge aclk);
        rdv(OFF_FLAGS, 16'h0000);
        rdv(OFF_COMMAND, 16'h0001);
        debug_halt <= 1'b0;
        wait_flag();
        rdv(OFF_RESULT, 16'h00cc);
        wr(OFF_CTRL, 16'h0009);
        debug_halt <= 1'b1;
        wr(OFF_COMMAND, 16'h0001);
        wait_flag();
        debug_halt <= 1'b0;
        rdv(OFF_RESULT, 16'h00cc);
        $display("debug test done");
    endtask : test_debug

    task automatic test_free_run_enable();
        int ticks;
        wr(OFF_CTRL, 16'h0003);
        wr(OFF_COMMAND, 16'h0001);
        wait_flag();
        wr(OFF_FLAGS, 16'h0001);
        wait_flag();
        rdv(OFF_COMMAND, 16'h0001);
        wr(OFF_CTRL, 16'h0000);
        wr(OFF_FLAGS, 16'h0001);
        ticks = 0;
        repeat (60) begin
            @(negedge aclk);
            ticks += int'(sar_clk_tick);
        end
        chk(16'(ticks), 16'h0000);
        chk({15'h0000, sar_enable}, 16'h0000);
        rdv(OFF_FLAGS, 16'h0000);
        $display("free run test done");
    endtask : test_free_run_enable

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // The longest path is a few hundred polls of a few cycles each.
    initial begin
        repeat (40000) @(posedge aclk);
        miscompares++;
        summarize();
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        wstrb = 4'hf;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {event_in, debug_halt, global_int_enable} = '0;
        miscompares = 0;
        samples_checked = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        test_reset();
        test_timing();
        test_poll();
        test_accum();
        test_event();
        test_debug();
        test_free_run_enable();
        summarize();
    end
endmodule : adcseq_top_tb
`default_nettype wire
